//--- dv/gtm_pin_model.sv
// Purpose: Pin-side model of the sources and loads on the timer pins
// Assumes: Every timer pin carries a pull-up, so an idle line reads high
// Notes:   Source edges land off the clock grid, after a set delay

`include "gtm_regs.svh"

module gtm_pin_model #(
    parameter int SRC_DLY_NS = 3
) (
    input  wire logic [`GTM_NCH-1:0] pin_o_i,
    input  wire logic [`GTM_NCH-1:0] pin_oe_i,
    input  wire logic [`GTM_NCH-1:0] src_en_i,
    input  wire logic [`GTM_NCH-1:0] src_val_i,
    output logic      [`GTM_NCH-1:0] pin_lvl_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [`GTM_NCH-1:0] src_lvl;

    // Late edges, so the timer must synchronise them itself
    assign #(SRC_DLY_NS) src_lvl = src_val_i;

    // Wire level: timer drive first, then source, else the pull-up
    always_comb begin
        for (int i = 0; i < `GTM_NCH; i++) begin
            if (pin_oe_i[i])
                pin_lvl_o[i] = pin_o_i[i];
            else if (src_en_i[i])
                pin_lvl_o[i] = src_lvl[i];
            else
                pin_lvl_o[i] = 1'b1;
        end
    end
endmodule

//--- dv/gtm_timer_tb_top.sv
// Purpose: Self-checking bench for the four-channel general timer
// Assumes: Pins see the pin model; channel one pin has no source
// Notes:   Inputs change on rising edges, outputs read on falling edges

`include "gtm_regs.svh"

module gtm_timer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import gtm_pkg::*;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic                   clk     = 1'b0;
    logic                   rst     = 1'b1;
    logic                   enable  = 1'b0;
    logic [2:0]             sel     = 3'h0;
    gtm_chan_cfg_type [3:0] cfg     = '0;
    logic [3:0]             fclr    = 4'h0;
    logic                   oclr    = 1'b0;
    gtm_pacc_cfg_type       pcfg    = '0;
    logic                   pclr    = 1'b0;
    logic [3:0]             src_en  = 4'hD;
    logic [3:0]             src_val = 4'h0;
    logic [3:0]             pin_lvl, pin_o, pin_oe, cflag;
    logic [3:0][15:0]       capt;
    logic [15:0]            count, pcount;
    logic                   oflag, povf;
    gtm_act_type            acts [4];
    logic [3:0]             pexp    = 4'hD;
    int                     err_count = 0;
    int                     n_checks  = 0;

    // Free-running 125 MHz clock
    always #4 clk = ~clk;

    gtm_timer dut (
        .clk_i           (clk),
        .rst_i           (rst),
        .enable_i        (enable),
        .prescale_sel_i  (sel),
        .chan_cfg_i      (cfg),
        .chan_flag_clr_i (fclr),
        .ovf_clr_i       (oclr),
        .pacc_cfg_i      (pcfg),
        .pacc_clr_i      (pclr),
        .pin_i           (pin_lvl),
        .pin_o           (pin_o),
        .pin_oe_o        (pin_oe),
        .count_o         (count),
        .capture_o       (capt),
        .chan_flag_o     (cflag),
        .ovf_flag_o      (oflag),
        .pacc_count_o    (pcount),
        .pacc_ovf_o      (povf)
    );

    gtm_pin_model pins (
        .pin_o_i   (pin_o),
        .pin_oe_i  (pin_oe),
        .src_en_i  (src_en),
        .src_val_i (src_val),
        .pin_lvl_o (pin_lvl)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Settled outputs only; never read in the launching time step
    task automatic sample();
        @(negedge clk);
    endtask

    // One level change on channel zero, then proof of a single capture when f is set, or of none when it is clear
    task automatic pin_step(input logic v, input logic f);
        logic [15:0] c;
        sample();
        c = count;
        @(posedge clk);
        src_val[0] <= v;
        cyc(8);
        sample();
        check(cflag[0], f);
        if (f)
            check(capt[0] - c >= 3 && capt[0] - c <= 8, 1'b1);
        @(posedge clk);
        fclr[0] <= 1'b1;
        @(posedge clk);
        fclr[0] <= 1'b0;
        cyc(8);
        sample();
        check(cflag[0], 1'b0);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] c;
        int          w;
        acts = '{GTM_ACT_SET, GTM_ACT_CLEAR, GTM_ACT_TOGGLE, GTM_ACT_NONE};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        sample();
        check(count, 16'h0000);
        check({cflag, pin_oe, pin_o}, 16'h0000);
        check(pcount, 16'h0000);
        check({oflag, povf}, 16'h0000);
        cyc(6);
        enable <= 1'b1;
        // Exactly two ticks in any 2^(n+1) clock window
        for (int n = 0; n < 8; n++) begin
            @(posedge clk);
            sel <= n[2:0];
            @(posedge clk);
            sample();
            c = count;
            cyc(2 << n);
            sample();
            check(count - c, 16'h0002);
        end
        @(posedge clk);
        enable <= 1'b0;
        // Divide-by-two on the restart below exercises the rate check
        sel <= 3'h1;
        cyc(2);
        sample();
        c = count;
        cyc(20);
        sample();
        check(count, c);
        @(posedge clk);
        enable <= 1'b1;
        @(posedge clk);
        sel <= 3'h0;
        // Every edge select against a rise and a fall
        for (int e = 0; e < 4; e++) begin
            @(posedge clk);
            cfg[0].edge_sel <= gtm_edge_type'(e);
            pin_step(1'b1, e[0]);
            pin_step(1'b0, e[1]);
        end
        // Compare actions while channel zero keeps capturing
        @(posedge clk);
        cfg[1].mode <= GTM_COMPARE;
        for (int k = 0; k < 4; k++) begin
            sample();
            c = count;
            @(posedge clk);
            cfg[1].act <= acts[k];
            cfg[1].compare <= c + 16'd30;
            fclr <= 4'h3;
            src_val[0] <= ~src_val[0];
            @(posedge clk);
            fclr <= 4'h0;
            w = 0;
            sample();
            while (cflag[1] !== 1'b1 && w < 60) begin
                sample();
                w++;
            end
            check(count, cfg[1].compare);
            check(pin_o[1], pexp[k]);
            check(pin_lvl[1], pexp[k]);
            check(cflag[0], 1'b1);
        end
        check(pin_oe, 4'h2);
        // Event counting on channel three, both polarities
        for (int a = 0; a < 2; a++) begin
            @(posedge clk);
            pcfg <= '{1'b1, GTM_PACC_EVENT, a[0]};
            src_val[3] <= a[0];
            cyc(8);
            pclr <= 1'b1;
            @(posedge clk);
            pclr <= 1'b0;
            for (int p = 0; p < 5; p++) begin
                @(posedge clk);
                src_val[3] <= ~a[0];
                src_val[0] <= ~src_val[0];
                cyc(6);
                src_val[3] <= a[0];
                cyc(6);
            end
            cyc(8);
            sample();
            check(pcount, 16'd5);
        end
        // Gated time: three divide-by-64 ticks in 192 clocks
        @(posedge clk);
        pcfg <= '{1'b1, GTM_PACC_GATED, 1'b0};
        src_val[3] <= 1'b1;
        cyc(8);
        pclr <= 1'b1;
        @(posedge clk);
        pclr <= 1'b0;
        cyc(192);
        sample();
        check(pcount, 16'd3);
        @(posedge clk);
        src_val[3] <= 1'b0;
        cyc(8);
        sample();
        c = pcount;
        cyc(200);
        sample();
        check(pcount, c);
        // Active-low gate: two divide-by-64 ticks in 128 clocks
        @(posedge clk);
        pcfg <= '{1'b1, GTM_PACC_GATED, 1'b1};
        pclr <= 1'b1;
        @(posedge clk);
        pclr <= 1'b0;
        cyc(128);
        sample();
        check(pcount, 16'd2);
        check(povf, 1'b0);
        // Counter wrap and the sticky overflow flag
        check(oflag, 1'b0);
        w = 0;
        while (count !== 16'hFFFF && w < 70000) begin
            sample();
            w++;
        end
        sample();
        check(count, 16'h0000);
        check(oflag, 1'b1);
        cyc(10);
        sample();
        check(oflag, 1'b1);
        @(posedge clk);
        oclr <= 1'b1;
        @(posedge clk);
        oclr <= 1'b0;
        sample();
        check(oflag, 1'b0);
        final_report();
    end

    // Watchdog: the sequence needs about 66100 cycles
    initial begin
        repeat (90000) @(posedge clk);
        err_count++;
        final_report();
    end
endmodule

//--- hdl/gtm_chan.sv
// Purpose: One timer channel: pin synchroniser, capture and compare
// Assumes: Counter value, next value and tick come from the top
// Notes:   Pin output only drives while the channel is in compare mode
`include "gtm_regs.svh"

module gtm_chan (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire gtm_pkg::gtm_chan_cfg_type    cfg_i,
    input  wire logic [`GTM_CNT_W-1:0]        cnt_i,
    input  wire logic [`GTM_CNT_W-1:0]        cnt_nxt_i,
    input  wire logic                         tick_i,
    input  wire logic                         pin_i,
    input  wire logic                         flag_clr_i,
    output logic      [`GTM_CNT_W-1:0]        capture_o,
    output logic                              flag_o,
    output logic                              pin_o,
    output logic                              pin_oe_o,
    output logic                              level_o,
    output logic                              rise_o,
    output logic                              fall_o
);
    import gtm_pkg::*;

    logic                  s1_q, s2_q, s3_q;
    logic                  filt_q, rise_q, fall_q;
    logic [`GTM_CNT_W-1:0] cap_q;
    logic                  flag_q, pin_q, oe_q;
    wire                   agree_w;
    wire                   cap_hit_w;
    wire                   cmp_hit_w;
    logic                  pin_d;

    // ------------------------------------------------------------
    // Synchroniser and edge detection
    // ------------------------------------------------------------
    // Level only moves once stages two and three agree
    assign agree_w = (s2_q == s3_q);

    // Three stages; the first feeds only the second. Pins idle high on
    // their pull-ups, so reset to that level to avoid a false rise
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q   <= 1'b1;
            s2_q   <= 1'b1;
            s3_q   <= 1'b1;
            filt_q <= 1'b1;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            s1_q   <= pin_i;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= agree_w ? s3_q : filt_q;
            rise_q <= agree_w && s3_q && !filt_q;
            fall_q <= agree_w && !s3_q && filt_q;
        end
    end

    // ------------------------------------------------------------
    // Capture and compare decode
    // ------------------------------------------------------------
    // Selected edge in capture mode
    assign cap_hit_w = (cfg_i.mode == GTM_CAPTURE) &&
                       ((cfg_i.edge_sel[0] && rise_q) ||
                        (cfg_i.edge_sel[1] && fall_q));
    // Match when the counter steps onto the compare value
    assign cmp_hit_w = (cfg_i.mode == GTM_COMPARE) && tick_i &&
                       (cnt_nxt_i == cfg_i.compare);

    // Pin action on a match
    always_comb begin
        pin_d = pin_q;
        if (cmp_hit_w) begin
            case (cfg_i.act)
                GTM_ACT_TOGGLE: pin_d = !pin_q;
                GTM_ACT_CLEAR:  pin_d = 1'b0;
                GTM_ACT_SET:    pin_d = 1'b1;
                default:        pin_d = pin_q;
            endcase
        end
    end

    // Registers; a new event beats a clear in the same cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cap_q  <= `GTM_CNT_ZERO;
            flag_q <= 1'b0;
            pin_q  <= 1'b0;
            oe_q   <= 1'b0;
        end else begin
            if (cap_hit_w) begin
                cap_q <= cnt_i;
            end
            flag_q <= cap_hit_w || cmp_hit_w || (flag_q && !flag_clr_i);
            pin_q  <= pin_d;
            oe_q   <= (cfg_i.mode == GTM_COMPARE);
        end
    end

    assign capture_o = cap_q;
    assign flag_o    = flag_q;
    assign pin_o     = pin_q;
    assign pin_oe_o  = oe_q;
    assign level_o   = filt_q;
    assign rise_o    = rise_q;
    assign fall_o    = fall_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_SYNC_LEVEL: assert property (
        pin_i [*5] |=> filt_q)
        else $error("stable high pin not seen as high level");
    AST_EDGE_ONCE: assert property (
        rise_q |=> !rise_q [*2])
        else $error("one pin edge reported more than once");
    AST_CAPTURE: assert property (
        cap_hit_w |=> (cap_q == $past(cnt_i)) && flag_q)
        else $error("capture did not store counter or set flag");
    AST_CMP_TOGGLE: assert property (
        cmp_hit_w && cfg_i.act == GTM_ACT_TOGGLE
            |=> pin_q != $past(pin_q) && flag_q)
        else $error("compare match did not toggle pin");
    AST_FLAG_SET_WINS: assert property (
        (cap_hit_w || cmp_hit_w) && flag_clr_i |=> flag_q)
        else $error("event lost against flag clear");
endmodule

//--- hdl/gtm_pkg.sv
// Purpose: Types shared by the general timer modules
// Assumes: gtm_regs.svh supplies the widths
// Notes:   Enum codes follow declaration order from zero
`include "gtm_regs.svh"

package gtm_pkg;

    // ------------------------------------------------------------
    // Channel and accumulator modes
    // ------------------------------------------------------------
    typedef enum logic {GTM_CAPTURE, GTM_COMPARE} gtm_mode_type;
    typedef enum logic [1:0] {
        GTM_EDGE_NONE,
        GTM_EDGE_RISE,
        GTM_EDGE_FALL,
        GTM_EDGE_BOTH
    } gtm_edge_type;
    typedef enum logic [1:0] {
        GTM_ACT_NONE,
        GTM_ACT_TOGGLE,
        GTM_ACT_CLEAR,
        GTM_ACT_SET
    } gtm_act_type;
    typedef enum logic {GTM_PACC_EVENT, GTM_PACC_GATED} gtm_pacc_type;

    // ------------------------------------------------------------
    // Configuration carriers
    // ------------------------------------------------------------
    typedef struct packed {
        gtm_mode_type               mode;
        gtm_edge_type               edge_sel;
        gtm_act_type                act;
        logic [`GTM_CNT_W-1:0]      compare;
    } gtm_chan_cfg_type;

    typedef struct packed {
        logic                       en;
        gtm_pacc_type               mode;
        logic                       active_low;
    } gtm_pacc_cfg_type;

endpackage

//--- hdl/gtm_regs.svh
// Purpose: Named constants for the four-channel general timer
// Assumes: Included by the package and the design modules
// Notes:   Definitions only, guarded against double inclusion
`ifndef GTM_REGS_SVH
`define GTM_REGS_SVH

// ----------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------
`define GTM_CNT_W         16
`define GTM_PRE_W         7
`define GTM_SEL_W         3
`define GTM_NCH           4
`define GTM_PACC_CH       3

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define GTM_CNT_ZERO      16'h0000
`define GTM_CNT_ONE       16'h0001
`define GTM_CNT_MAX       16'hFFFF
`define GTM_PRE_ZERO      7'h00
`define GTM_PRE_ONE       7'h01
`define GTM_PRE_ONES      7'h7F
`define GTM_SEL_DIV1      3'h0
`define GTM_SEL_DIV2      3'h1
// Gated accumulation advances on the divide-by-64 prescaler stage
`define GTM_PACC_GATE_SEL 3'h6

`endif

//--- hdl/gtm_timer.sv
// Purpose: Four-channel general timer with pulse accumulator
// Assumes: Single clock; configuration arrives on plain ports
// Notes:   Divide select n gives a counter tick every 2^n clocks
`include "gtm_regs.svh"

module gtm_timer (
    input  wire logic                                   clk_i,
    input  wire logic                                   rst_i,
    input  wire logic                                   enable_i,
    input  wire logic [`GTM_SEL_W-1:0]                  prescale_sel_i,
    input  wire gtm_pkg::gtm_chan_cfg_type [`GTM_NCH-1:0] chan_cfg_i,
    input  wire logic [`GTM_NCH-1:0]                    chan_flag_clr_i,
    input  wire logic                                   ovf_clr_i,
    input  wire gtm_pkg::gtm_pacc_cfg_type              pacc_cfg_i,
    input  wire logic                                   pacc_clr_i,
    input  wire logic [`GTM_NCH-1:0]                    pin_i,
    output logic      [`GTM_NCH-1:0]                    pin_o,
    output logic      [`GTM_NCH-1:0]                    pin_oe_o,
    output logic      [`GTM_CNT_W-1:0]                  count_o,
    output logic      [`GTM_NCH-1:0][`GTM_CNT_W-1:0]    capture_o,
    output logic      [`GTM_NCH-1:0]                    chan_flag_o,
    output logic                                        ovf_flag_o,
    output logic      [`GTM_CNT_W-1:0]                  pacc_count_o,
    output logic                                        pacc_ovf_o
);
    import gtm_pkg::*;

    logic [`GTM_PRE_W-1:0] presc_q;
    logic [`GTM_CNT_W-1:0] cnt_q;
    logic                  ovf_q;
    logic [`GTM_CNT_W-1:0] pacc_q;
    logic                  pacc_ovf_q;
    wire                   tick_w;
    wire                   gate_tick_w;
    wire                   wrap_w;
    wire  [`GTM_CNT_W-1:0] cnt_nxt_w;
    wire  [`GTM_NCH-1:0]   level_w, rise_w, fall_w;
    wire                   gate_on_w;
    wire                   pacc_evt_w;
    wire                   pacc_inc_w;
    wire                   pacc_wrap_w;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Tick when the low sel bits of the prescaler are all ones
    function automatic logic presc_tick(input logic [`GTM_PRE_W-1:0] c,
                                        input logic [`GTM_SEL_W-1:0] s);
        logic [`GTM_PRE_W-1:0] m;
        m = ~(`GTM_PRE_ONES << s);
        return (c & m) == m;
    endfunction

    function automatic logic [`GTM_CNT_W-1:0] inc16(
        input logic [`GTM_CNT_W-1:0] v);
        return v + `GTM_CNT_ONE;
    endfunction

    // ------------------------------------------------------------
    // Prescaler and main counter
    // ------------------------------------------------------------
    // Seven-stage prescaler taps select the counter rate
    assign tick_w      = enable_i && presc_tick(presc_q, prescale_sel_i);
    assign gate_tick_w = enable_i && presc_tick(presc_q, `GTM_PACC_GATE_SEL);
    assign cnt_nxt_w   = inc16(cnt_q);
    assign wrap_w      = tick_w && (cnt_q == `GTM_CNT_MAX);

    // Prescaler restarts while disabled so the first tick is predictable
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            presc_q <= `GTM_PRE_ZERO;
        end else if (enable_i) begin
            presc_q <= presc_q + `GTM_PRE_ONE;
        end else begin
            presc_q <= `GTM_PRE_ZERO;
        end
    end

    // Counter and sticky overflow; overflow beats a clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= `GTM_CNT_ZERO;
            ovf_q <= 1'b0;
        end else begin
            if (tick_w) begin
                cnt_q <= cnt_nxt_w;
            end
            ovf_q <= wrap_w || (ovf_q && !ovf_clr_i);
        end
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    // Independent channels share the counter, so capture and compare
    // run together
    for (genvar i = 0; i < `GTM_NCH; i++) begin : g_ch
        gtm_chan u_chan (
            .clk_i      (clk_i),
            .rst_i      (rst_i),
            .cfg_i      (chan_cfg_i[i]),
            .cnt_i      (cnt_q),
            .cnt_nxt_i  (cnt_nxt_w),
            .tick_i     (tick_w),
            .pin_i      (pin_i[i]),
            .flag_clr_i (chan_flag_clr_i[i]),
            .capture_o  (capture_o[i]),
            .flag_o     (chan_flag_o[i]),
            .pin_o      (pin_o[i]),
            .pin_oe_o   (pin_oe_o[i]),
            .level_o    (level_w[i]),
            .rise_o     (rise_w[i]),
            .fall_o     (fall_w[i])
        );
    end

    // ------------------------------------------------------------
    // Pulse accumulator on channel three
    // ------------------------------------------------------------
    // Only the channel three pin feeds the accumulator
    assign gate_on_w  = level_w[`GTM_PACC_CH] ^ pacc_cfg_i.active_low;
    assign pacc_evt_w = pacc_cfg_i.active_low ? fall_w[`GTM_PACC_CH]
                                              : rise_w[`GTM_PACC_CH];
    // Event count or gated time
    assign pacc_inc_w = pacc_cfg_i.en &&
        ((pacc_cfg_i.mode == GTM_PACC_EVENT) ? pacc_evt_w
                                             : (gate_on_w && gate_tick_w));
    assign pacc_wrap_w = pacc_inc_w && (pacc_q == `GTM_CNT_MAX);

    // Clear restarts the count; a wrap in that cycle still sets overflow
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pacc_q     <= `GTM_CNT_ZERO;
            pacc_ovf_q <= 1'b0;
        end else begin
            if (pacc_clr_i) begin
                pacc_q <= `GTM_CNT_ZERO;
            end else if (pacc_inc_w) begin
                pacc_q <= inc16(pacc_q);
            end
            pacc_ovf_q <= pacc_wrap_w || (pacc_ovf_q && !pacc_clr_i);
        end
    end

    assign count_o      = cnt_q;
    assign ovf_flag_o   = ovf_q;
    assign pacc_count_o = pacc_q;
    assign pacc_ovf_o   = pacc_ovf_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_full_rate;
        enable_i && prescale_sel_i == `GTM_SEL_DIV1 ##1 enable_i;
    endsequence

    AST_FULL_RATE: assert property (
        enable_i && prescale_sel_i == `GTM_SEL_DIV1
            |=> cnt_q == inc16($past(cnt_q)))
        else $error("counter missed a divide-by-one tick");
    AST_DIV_RATE: assert property (
        !enable_i ##1 enable_i && prescale_sel_i == `GTM_SEL_DIV2 && $stable(
            prescale_sel_i) |=> $stable(cnt_q) ##1 cnt_q != $past(cnt_q))
        else $error("divide-by-two prescaler rate wrong");
    AST_HOLD: assert property (
        !enable_i |=> $stable(cnt_q))
        else $error("counter moved while disabled");
    AST_WRAP: assert property (
        wrap_w |=> cnt_q == `GTM_CNT_ZERO && ovf_q)
        else $error("counter wrap did not set overflow");
    AST_OVF_STICKY: assert property (
        ovf_q && !ovf_clr_i |=> ovf_q)
        else $error("overflow flag dropped without clear");
    AST_PACC_EVENT: assert property (
        pacc_cfg_i.en && pacc_cfg_i.mode == GTM_PACC_EVENT && pacc_evt_w
            && !pacc_clr_i |=> pacc_q == inc16($past(pacc_q)))
        else $error("accumulator missed an event");
    AST_PACC_GATE_OFF: assert property (
        pacc_cfg_i.mode == GTM_PACC_GATED && !gate_on_w && !pacc_clr_i
            |=> $stable(pacc_q))
        else $error("accumulator counted with gate closed");
    AST_FULL_RATE_RUN: assert property (
        s_full_rate and (prescale_sel_i == `GTM_SEL_DIV1) [*2]
            |=> cnt_q == inc16(inc16($past(cnt_q, 2))))
        else $error("counter did not advance on successive ticks");
endmodule
